/* File: rtl/emr_defines.svh */
// Offsets, field positions, reset values and codes of the explicit message engine
`ifndef EMR_DEFINES_SVH
`define EMR_DEFINES_SVH
// ----------------------------------------
// Control block word offsets
// ----------------------------------------
`define EMR_ADDR_OPERATION 8'h00
`define EMR_ADDR_EVENT 8'h01
`define EMR_ADDR_BUF_LEN 8'h02
`define EMR_ADDR_RESP_OFF 8'h03
`define EMR_ADDR_ROUTING 8'h04
`define EMR_ADDR_IP_UPPER 8'h05
`define EMR_ADDR_IP_LOWER 8'h06
`define EMR_ADDR_REQ_LEN 8'h07
`define EMR_ADDR_RESP_LEN 8'h08
// ----------------------------------------
// Engine control, interrupt and buffer window
// ----------------------------------------
`define EMR_ADDR_IRQ_STATUS 8'h10
`define EMR_ADDR_IRQ_MASK 8'h11
`define EMR_ADDR_COMMAND 8'h12
`define EMR_ADDR_BUF_BASE 8'h40
`define EMR_BUF_WORDS 16'h0040
`define EMR_CMD_START_BIT 0
`define EMR_IRQ_DONE_BIT 0
`define EMR_IRQ_ERROR_BIT 1
// ----------------------------------------
// Operation codes and protocol constants
// ----------------------------------------
`define EMR_OP_UNCONNECTED 16'h000e
`define EMR_OP_CONNECTED 16'h010e
`define EMR_REPLY_FLAG 8'h80
`define EMR_RESP_HDR_BYTES 16'h0004
`define EMR_RESET_WORD 16'h0000
// ----------------------------------------
// Event codes
// ----------------------------------------
`define EMR_EVT_OK 16'h0000
`define EMR_EVT_BAD_OP 16'h0001
`define EMR_EVT_BAD_LEN 16'h0002
`define EMR_EVT_OVERFLOW 16'h0003
`define EMR_EVT_BAD_REPLY 16'h0004
`define EMR_EVT_SHORT 16'h0005
`define EMR_EVT_CIP_STATUS 16'h0006
`endif

/* File: rtl/emr_pkg.sv */
// Types shared by the explicit message engine
package emr_pkg;
  // Transaction sequencer states
  typedef enum logic [2:0] {
    EMR_IDLE = 3'b000,
    EMR_CHECK = 3'b001,
    EMR_SEND = 3'b010,
    EMR_RECV = 3'b011,
    EMR_DONE = 3'b100
  } emr_state_t;
endpackage

/* File: rtl/emr_engine.sv */
// Explicit message engine: control block, message buffer, request send and response capture
`timescale 1ns/1ps
`include "emr_defines.svh"

module emr_engine
  import emr_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  output logic irq_out,
  output logic busy_out,
  output logic connected_out,
  output logic [31:0] target_ip_out,
  output logic [15:0] routing_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Little-endian lane pick: even byte is the low half of a word
  function automatic logic [7:0] emr_byte_sel(input logic [15:0] word, input logic lane);
    emr_byte_sel = lane ? word[15:8] : word[7:0];
  endfunction

  // Buffer window decode: the top two address bits select the message buffer
  function automatic logic emr_is_buf(input logic [7:0] addr);
    emr_is_buf = addr[7:6] == 2'(`EMR_ADDR_BUF_BASE >> 6);
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] buf_mem [0:63];
  logic [15:0] operation_q;
  logic [15:0] event_code_q;
  logic [15:0] buf_len_q;
  logic [15:0] resp_off_q;
  logic [15:0] routing_q;
  logic [15:0] ip_upper_q;
  logic [15:0] ip_lower_q;
  logic [15:0] req_len_q;
  logic [15:0] resp_len_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  emr_state_t state_q;
  logic [15:0] tx_idx_q;
  logic [15:0] rx_cnt_q;
  logic [7:0] service_q;
  logic [15:0] evt_q;
  logic done_set;
  logic [15:0] rx_word;
  logic rx_in_range;
  logic rx_wr;
  logic [7:0] rx_byte;
  logic start_req;
  logic bus_wr_buf;

  assign start_req = wr_in && (addr_in == `EMR_ADDR_COMMAND) && wr_data_in[`EMR_CMD_START_BIT] &&
    (state_q == EMR_IDLE);
  assign bus_wr_buf = wr_in && emr_is_buf(addr_in) && (state_q == EMR_IDLE);
  assign rx_word = resp_off_q + {1'b0, rx_cnt_q[15:1]};
  assign rx_in_range = rx_word < buf_len_q;
  assign rx_wr = (state_q == EMR_RECV) && rx_valid_in && rx_in_range;
  assign done_set = state_q == EMR_DONE;
  // Reserved reply byte is stored as zero whatever arrives
  assign rx_byte = (rx_cnt_q == 16'h0001) ? 8'h00 : rx_data_in;

  // ----------------------------------------
  // Control words written by software
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      operation_q <= `EMR_RESET_WORD;
      buf_len_q <= `EMR_RESET_WORD;
      resp_off_q <= `EMR_RESET_WORD;
      routing_q <= `EMR_RESET_WORD;
      ip_upper_q <= `EMR_RESET_WORD;
      ip_lower_q <= `EMR_RESET_WORD;
      req_len_q <= `EMR_RESET_WORD;
      irq_mask_q <= 2'h0;
    end else if (wr_in) begin
      case (addr_in)
        `EMR_ADDR_OPERATION: operation_q <= wr_data_in;
        `EMR_ADDR_BUF_LEN: buf_len_q <= wr_data_in;
        `EMR_ADDR_RESP_OFF: resp_off_q <= wr_data_in;
        `EMR_ADDR_ROUTING: routing_q <= wr_data_in;
        `EMR_ADDR_IP_UPPER: ip_upper_q <= wr_data_in;
        `EMR_ADDR_IP_LOWER: ip_lower_q <= wr_data_in;
        `EMR_ADDR_REQ_LEN: req_len_q <= wr_data_in;
        `EMR_ADDR_IRQ_MASK: irq_mask_q <= wr_data_in[1:0];
        default: ;  // Event code and response length ignore writes
      endcase
    end
  end

  // ----------------------------------------
  // Message buffer: bus writes while idle, response bytes while receiving
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rx_wr) begin
      if (rx_cnt_q[0]) begin
        buf_mem[rx_word[5:0]][15:8] <= rx_byte;
      end else begin
        buf_mem[rx_word[5:0]][7:0] <= rx_byte;
      end
    end else if (bus_wr_buf) begin
      buf_mem[addr_in[5:0]] <= wr_data_in;
    end
  end

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= EMR_IDLE;
      tx_idx_q <= 16'h0000;
      rx_cnt_q <= 16'h0000;
      service_q <= 8'h00;
      evt_q <= `EMR_EVT_OK;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_last_out <= 1'b0;
    end else begin
      case (state_q)
        EMR_IDLE: begin
          if (start_req) begin
            state_q <= EMR_CHECK;
          end
        end
        EMR_CHECK: begin
          tx_idx_q <= 16'h0000;
          rx_cnt_q <= 16'h0000;
          service_q <= emr_byte_sel(buf_mem[0], 1'b0);
          if ((operation_q != `EMR_OP_UNCONNECTED) && (operation_q != `EMR_OP_CONNECTED)) begin
            evt_q <= `EMR_EVT_BAD_OP;
            state_q <= EMR_DONE;
          end else if ((buf_len_q == 16'h0000) || (buf_len_q > `EMR_BUF_WORDS) || (req_len_q == 16'h0000) ||
              ({1'b0, req_len_q} > {buf_len_q, 1'b0}) || (resp_off_q >= buf_len_q)) begin
            evt_q <= `EMR_EVT_BAD_LEN;
            state_q <= EMR_DONE;
          end else begin
            evt_q <= `EMR_EVT_OK;
            tx_valid_out <= 1'b1;
            tx_data_out <= emr_byte_sel(buf_mem[0], 1'b0);
            tx_last_out <= req_len_q == 16'h0001;
            state_q <= EMR_SEND;
          end
        end
        EMR_SEND: begin
          // Bytes go out in buffer order: service, path size, path, payload
          if (tx_ready_in) begin
            if (tx_last_out) begin
              tx_valid_out <= 1'b0;
              tx_last_out <= 1'b0;
              state_q <= EMR_RECV;
            end else begin
              tx_idx_q <= tx_idx_q + 16'h0001;
              tx_data_out <= emr_byte_sel(buf_mem[tx_idx_q[6:1] + {5'h00, tx_idx_q[0]}], ~tx_idx_q[0]);
              tx_last_out <= (tx_idx_q + 16'h0002) == req_len_q;
            end
          end
        end
        EMR_RECV: begin
          if (rx_valid_in) begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
            // Short check first so a header fault seen on the same byte takes precedence
            if (rx_last_in) begin
              if (((rx_cnt_q + 16'h0001) < `EMR_RESP_HDR_BYTES) && (evt_q == `EMR_EVT_OK)) begin
                evt_q <= `EMR_EVT_SHORT;
              end
              state_q <= EMR_DONE;
            end
            if (!rx_in_range) begin
              evt_q <= `EMR_EVT_OVERFLOW;
            end else if ((rx_cnt_q == 16'h0000) && (rx_data_in != (service_q + `EMR_REPLY_FLAG))) begin
              evt_q <= `EMR_EVT_BAD_REPLY;
            end else if ((rx_cnt_q == 16'h0002) && (rx_data_in != 8'h00) && (evt_q == `EMR_EVT_OK)) begin
              evt_q <= `EMR_EVT_CIP_STATUS;
            end
          end
        end
        EMR_DONE: begin
          state_q <= EMR_IDLE;
        end
        default: begin
          state_q <= EMR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Result words, published only at the end of a transaction
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      event_code_q <= `EMR_EVT_OK;
      resp_len_q <= `EMR_RESET_WORD;
    end else if (done_set) begin
      event_code_q <= evt_q;
      resp_len_q <= rx_cnt_q;
    end
  end

  // ----------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_status_q <= 2'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_in && addr_in == `EMR_ADDR_IRQ_STATUS) ? wr_data_in[1:0] : 2'h0)) |
        {done_set && (evt_q != `EMR_EVT_OK), done_set};
    end
  end

  // ----------------------------------------
  // Registered outputs toward the network side and the interrupt line
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
      busy_out <= 1'b0;
      connected_out <= 1'b0;
      target_ip_out <= 32'h0000_0000;
      routing_out <= 16'h0000;
    end else begin
      irq_out <= |(irq_status_q & irq_mask_q);
      busy_out <= (state_q != EMR_IDLE) || start_req;
      if (state_q == EMR_CHECK) begin
        connected_out <= operation_q == `EMR_OP_CONNECTED;
        target_ip_out <= {ip_upper_q, ip_lower_q};
        routing_out <= routing_q;
      end
    end
  end

  // ----------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_in) begin
      if (emr_is_buf(addr_in)) begin
        rd_data_out <= buf_mem[addr_in[5:0]];
      end else begin
        case (addr_in)
          `EMR_ADDR_OPERATION: rd_data_out <= operation_q;
          `EMR_ADDR_EVENT: rd_data_out <= event_code_q;
          `EMR_ADDR_BUF_LEN: rd_data_out <= buf_len_q;
          `EMR_ADDR_RESP_OFF: rd_data_out <= resp_off_q;
          `EMR_ADDR_ROUTING: rd_data_out <= routing_q;
          `EMR_ADDR_IP_UPPER: rd_data_out <= ip_upper_q;
          `EMR_ADDR_IP_LOWER: rd_data_out <= ip_lower_q;
          `EMR_ADDR_REQ_LEN: rd_data_out <= req_len_q;
          `EMR_ADDR_RESP_LEN: rd_data_out <= resp_len_q;
          `EMR_ADDR_IRQ_STATUS: rd_data_out <= {14'h0000, irq_status_q};
          `EMR_ADDR_IRQ_MASK: rd_data_out <= {14'h0000, irq_mask_q};
          `EMR_ADDR_COMMAND: rd_data_out <= {15'h0000, state_q != EMR_IDLE};
          default: rd_data_out <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking emr_cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  bad_op_event_a: assert property (
    (state_q == EMR_CHECK) && (operation_q != `EMR_OP_UNCONNECTED) && (operation_q != `EMR_OP_CONNECTED)
    |-> ##2 (event_code_q == `EMR_EVT_BAD_OP))
    else $error("Invalid operation not reported");

  event_write_ignored_a: assert property (
    (state_q == EMR_IDLE) && wr_in && (addr_in == `EMR_ADDR_EVENT) |=> $stable(event_code_q))
    else $error("Event code changed by a write");

  resp_len_final_a: assert property (
    done_set |=> (resp_len_q == $past(rx_cnt_q)))
    else $error("Response length not the received count");

  first_byte_sent_a: assert property (
    (state_q == EMR_CHECK) ##1 (state_q == EMR_SEND) |-> (tx_valid_out && tx_data_out == buf_mem[0][7:0]))
    else $error("Request does not start at buffer byte zero");

  reply_service_check_a: assert property (
    (state_q == EMR_RECV) && rx_valid_in && rx_in_range && (rx_cnt_q == 16'h0000) &&
    (rx_data_in != service_q + `EMR_REPLY_FLAG) |=> (evt_q == `EMR_EVT_BAD_REPLY))
    else $error("Wrong reply service accepted");

  reserved_zero_a: assert property (
    rx_wr && (rx_cnt_q == 16'h0001) |=> (buf_mem[$past(rx_word[5:0])][15:8] == 8'h00))
    else $error("Reserved reply byte not zero");

  length_reject_a: assert property (
    (state_q == EMR_CHECK) && (operation_q == `EMR_OP_UNCONNECTED) && (resp_off_q >= buf_len_q)
    |=> (state_q == EMR_DONE) ##1 (event_code_q != `EMR_EVT_OK))
    else $error("Bad response offset accepted");

  no_write_outside_a: assert property (
    rx_wr |-> (rx_word < buf_len_q) && (rx_word < `EMR_BUF_WORDS))
    else $error("Response written past the buffer");

  results_stable_a: assert property (
    (state_q == EMR_SEND) || (state_q == EMR_RECV) |=> $stable(event_code_q) && $stable(resp_len_q))
    else $error("Result words moved mid transaction");

  tx_byte_hold_a: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
    else $error("Request byte moved before it was taken");

  tx_last_mark_a: assert property (
    tx_valid_out && tx_last_out |-> ((tx_idx_q + 16'h0001) == req_len_q))
    else $error("Last request byte flag misplaced");

  reject_silent_a: assert property (
    (state_q == EMR_CHECK) ##1 (state_q == EMR_DONE) |-> !tx_valid_out)
    else $error("Rejected request still sent bytes");

  connected_latch_a: assert property (
    (state_q == EMR_CHECK) |=> (connected_out == ($past(operation_q) == `EMR_OP_CONNECTED)))
    else $error("Connected flag does not follow the operation");

  ip_octet_order_a: assert property (
    (state_q == EMR_CHECK) |=> (target_ip_out[31:24] == $past(ip_upper_q[15:8])) &&
    (target_ip_out[7:0] == $past(ip_lower_q[7:0])))
    else $error("Target address octets out of order");

  reply_low_lane_a: assert property (
    rx_wr && !rx_cnt_q[0] |=> (buf_mem[$past(rx_word[5:0])][7:0] == $past(rx_byte)))
    else $error("Even reply byte not in the low half");

  short_reply_a: assert property (
    (state_q == EMR_RECV) && rx_valid_in && rx_last_in && rx_in_range && (rx_cnt_q == 16'h0002) &&
    (rx_data_in == 8'h00) && (evt_q == `EMR_EVT_OK) |=> (evt_q == `EMR_EVT_SHORT))
    else $error("Short reply not reported");

endmodule

/* File: dv/emr_target_model.sv */
// Behavioural network target that answers explicit message requests
`timescale 1ns/1ps
module emr_target_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic bad_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] total_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out,
  output logic [7:0] svc_out,
  output logic [15:0] nbytes_out,
  output logic [7:0] last_byte_out
);
  logic tick_q;
  logic resp_q;
  logic first_q;
  logic [7:0] k_q;
  logic [7:0] byte_d;
  // Slow mode accepts and answers only every other cycle
  assign tx_ready_out = slow_in ? tick_q : 1'b1;
  // Reply service, reserved zero, status, empty additional status, then data
  always_comb begin
    case (k_q)
      8'h00: byte_d = (svc_out + 8'h80) ^ {7'h00, bad_in};
      8'h01: byte_d = 8'h00;
      8'h02: byte_d = status_in;
      8'h03: byte_d = 8'h00;
      default: byte_d = k_q;
    endcase
  end
  // Takes request bytes, then streams the response; idle data keeps toggling
  always @(posedge clk_in) begin
    if (rst_in) begin
      tick_q <= 1'b0;
      resp_q <= 1'b0;
      first_q <= 1'b1;
      k_q <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_last_out <= 1'b0;
      svc_out <= 8'h00;
      nbytes_out <= 16'h0000;
      last_byte_out <= 8'h00;
    end else begin
      tick_q <= ~tick_q;
      if (tx_valid_in && tx_ready_out) begin
        if (first_q) begin
          svc_out <= tx_data_in;
        end
        first_q <= 1'b0;
        if (tx_last_in) begin
          last_byte_out <= tx_data_in;
        end
        nbytes_out <= nbytes_out + 16'h0001;
        resp_q <= tx_last_in;
        k_q <= 8'h00;
      end
      if (resp_q && (!slow_in || tick_q)) begin
        rx_valid_out <= 1'b1;
        rx_data_out <= byte_d;
        rx_last_out <= (k_q == total_in - 8'h01);
        k_q <= k_q + 8'h01;
        if (k_q == total_in - 8'h01) begin
          resp_q <= 1'b0;
          first_q <= 1'b1;
        end
      end else begin
        rx_valid_out <= 1'b0;
        rx_data_out <= ~rx_data_out;
        rx_last_out <= 1'b0;
      end
    end
  end
endmodule

/* File: dv/emr_engine_tb_top.sv */
// Self-checking bench for the explicit message engine
`timescale 1ns/1ps
`include "emr_defines.svh"
module emr_engine_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic bad = 1'b0;
  logic [7:0] status = 8'h00;
  logic [7:0] total = 8'h06;
  logic [15:0] rdata, routing, nbytes, nb0;
  logic [31:0] ip;
  logic [7:0] txd, rxd, svc, lastb;
  logic irq, busy, conn, txv, txl, txr, rxv, rxl;
  int err_count = 0;
  int cmp_count = 0;
  emr_engine uut (.core_clk_in(clk), .reset_in(rst), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr),
    .rd_in(rd), .rd_data_out(rdata), .irq_out(irq), .busy_out(busy), .connected_out(conn),
    .target_ip_out(ip), .routing_out(routing), .tx_valid_out(txv), .tx_data_out(txd), .tx_last_out(txl),
    .tx_ready_in(txr), .rx_valid_in(rxv), .rx_data_in(rxd), .rx_last_in(rxl));
  emr_target_model peer (.clk_in(clk), .rst_in(rst), .slow_in(slow), .bad_in(bad), .status_in(status),
    .total_in(total), .tx_valid_in(txv), .tx_data_in(txd), .tx_last_in(txl), .tx_ready_out(txr),
    .rx_valid_out(rxv), .rx_data_out(rxd), .rx_last_out(rxl), .svc_out(svc), .nbytes_out(nbytes),
    .last_byte_out(lastb));
  // ----------------------------------------
  // Bus and comparison helpers
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic expect_reg(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask
  task automatic run_txn(input logic [15:0] op, input logic [15:0] bl, input logic [15:0] off,
    input logic [15:0] rl);
    nb0 = nbytes;
    wr_reg(`EMR_ADDR_OPERATION, op);
    wr_reg(`EMR_ADDR_BUF_LEN, bl);
    wr_reg(`EMR_ADDR_RESP_OFF, off);
    wr_reg(`EMR_ADDR_REQ_LEN, rl);
    wr_reg(`EMR_ADDR_COMMAND, 16'h0001);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) return;
    end
    err_count++;
    $display("mismatch busy expected 0 seen 1");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 9; a++) expect_reg("ctl_word", a[7:0], 16'h0000);
    expect_reg("unmapped", 8'h20, 16'h0000);
    wr_reg(`EMR_ADDR_EVENT, 16'hffff);
    expect_reg("event_ro", `EMR_ADDR_EVENT, 16'h0000);
    wr_reg(`EMR_ADDR_RESP_LEN, 16'hffff);
    expect_reg("resp_len_ro", `EMR_ADDR_RESP_LEN, 16'h0000);
  endtask
  task automatic t_ok();
    wr_reg(`EMR_ADDR_ROUTING, 16'hfe05);
    wr_reg(`EMR_ADDR_IP_UPPER, 16'hc0a8);
    wr_reg(`EMR_ADDR_IP_LOWER, 16'h0106);
    wr_reg(8'h40, 16'h020e);
    wr_reg(8'h41, 16'h0420);
    wr_reg(8'h42, 16'h6424);
    wr_reg(`EMR_ADDR_IRQ_MASK, 16'h0003);
    run_txn(`EMR_OP_UNCONNECTED, 16'h0010, 16'h0004, 16'h0006);
    wait_idle();
    chk("connected", {15'h0000, conn}, 16'h0000);
    chk("ip_high", ip[31:16], 16'hc0a8);
    chk("ip_low", ip[15:0], 16'h0106);
    chk("routing", routing, 16'hfe05);
    chk("service", {8'h00, svc}, 16'h000e);
    chk("req_bytes", nbytes - nb0, 16'h0006);
    chk("last_req_byte", {8'h00, lastb}, 16'h0064);
    expect_reg("event", `EMR_ADDR_EVENT, `EMR_EVT_OK);
    expect_reg("resp_len", `EMR_ADDR_RESP_LEN, 16'h0006);
    expect_reg("reply_svc", 8'h44, 16'h008e);
    expect_reg("status", 8'h45, 16'h0000);
    expect_reg("reply_data", 8'h46, 16'h0504);
    expect_reg("request_kept", 8'h42, 16'h6424);
    chk("irq_set", {15'h0000, irq}, 16'h0001);
    wr_reg(`EMR_ADDR_IRQ_STATUS, 16'h0003);
    expect_reg("irq_clr", `EMR_ADDR_IRQ_STATUS, 16'h0000);
    chk("irq_low", {15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_conn();
    slow <= 1'b1;
    status <= 8'h08;
    wr_reg(`EMR_ADDR_IRQ_MASK, 16'h0000);
    run_txn(`EMR_OP_CONNECTED, 16'h0010, 16'h0008, 16'h0006);
    expect_reg("event_busy", `EMR_ADDR_EVENT, `EMR_EVT_OK);
    expect_reg("len_busy", `EMR_ADDR_RESP_LEN, 16'h0006);
    chk("busy", {15'h0000, busy}, 16'h0001);
    wait_idle();
    chk("connected", {15'h0000, conn}, 16'h0001);
    chk("req_bytes", nbytes - nb0, 16'h0006);
    expect_reg("event", `EMR_ADDR_EVENT, `EMR_EVT_CIP_STATUS);
    expect_reg("status", 8'h49, 16'h0008);
    expect_reg("reply_data", 8'h4a, 16'h0504);
    chk("irq_masked", {15'h0000, irq}, 16'h0000);
    wr_reg(`EMR_ADDR_IRQ_MASK, 16'h0002);
    expect_reg("mask", `EMR_ADDR_IRQ_MASK, 16'h0002);
    chk("irq_err", {15'h0000, irq}, 16'h0001);
    wr_reg(`EMR_ADDR_IRQ_STATUS, 16'h0003);
    expect_reg("irq_clr", `EMR_ADDR_IRQ_STATUS, 16'h0000);
    chk("irq_low", {15'h0000, irq}, 16'h0000);
    slow <= 1'b0;
    status <= 8'h00;
  endtask
  task automatic t_refuse();
    logic [15:0] tbl [6][5] = '{'{16'h0005, 16'h0008, 16'h0004, 16'h0004, `EMR_EVT_BAD_OP},
      '{16'h000e, 16'h0000, 16'h0000, 16'h0004, `EMR_EVT_BAD_LEN},
      '{16'h000e, 16'h0041, 16'h0004, 16'h0004, `EMR_EVT_BAD_LEN},
      '{16'h000e, 16'h0008, 16'h0004, 16'h0000, `EMR_EVT_BAD_LEN},
      '{16'h000e, 16'h0008, 16'h0004, 16'h0011, `EMR_EVT_BAD_LEN},
      '{16'h000e, 16'h0008, 16'h0008, 16'h0004, `EMR_EVT_BAD_LEN}};
    for (int i = 0; i < 6; i++) begin
      run_txn(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
      wait_idle();
      expect_reg("refuse_event", `EMR_ADDR_EVENT, tbl[i][4]);
      chk("refuse_bytes", nbytes - nb0, 16'h0000);
    end
  endtask
  task automatic t_bad_reply();
    bad <= 1'b1;
    run_txn(`EMR_OP_UNCONNECTED, 16'h0010, 16'h0004, 16'h0006);
    wait_idle();
    expect_reg("bad_reply", `EMR_ADDR_EVENT, `EMR_EVT_BAD_REPLY);
    bad <= 1'b0;
    total <= 8'h03;
    run_txn(`EMR_OP_UNCONNECTED, 16'h0010, 16'h0004, 16'h0006);
    wait_idle();
    expect_reg("short", `EMR_ADDR_EVENT, `EMR_EVT_SHORT);
    expect_reg("short_len", `EMR_ADDR_RESP_LEN, 16'h0003);
    total <= 8'h06;
  endtask
  task automatic t_overflow();
    wr_reg(8'h48, 16'ha5a5);
    run_txn(`EMR_OP_UNCONNECTED, 16'h0008, 16'h0007, 16'h0004);
    wait_idle();
    expect_reg("overflow", `EMR_ADDR_EVENT, `EMR_EVT_OVERFLOW);
    chk("ovf_last_byte", {8'h00, lastb}, 16'h0004);
    expect_reg("ovf_len", `EMR_ADDR_RESP_LEN, 16'h0006);
    expect_reg("beyond_buf", 8'h48, 16'ha5a5);
    expect_reg("over_request", 8'h47, 16'h008e);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run length
  initial begin
    #500us;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ok();
    t_conn();
    t_refuse();
    t_bad_reply();
    t_overflow();
    wrap_up();
  end
endmodule
